// ---- bench/bus_master.sv ----
// Bus master model driving the two-wire serial lines
`timescale 1ns/1ps
module bus_master (
  input  wire logic clk,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_m
);
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Start or repeated start, a single condition in this high phase
  task automatic start();
    tick(4);
    sda_m <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_m <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask : start

  // Stop ends a transfer, clock then rests high
  task automatic stop();
    tick(4);
    sda_m <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_m <= 1'b1;
    tick(8);
  endtask : stop

  // One clock pulse, data set mid low phase, wire sampled late in high phase
  task automatic bit_io(input logic b, output logic s);
    tick(2);
    sda_m <= b;
    tick(2);
    scl <= 1'b1;
    tick(4);
    s = sda_w;
    scl <= 1'b0;
  endtask : bit_io

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask : wbyte

  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, s);
  endtask : rbyte
endmodule : bus_master

// ---- bench/clock_gen_i2c_slave_port_bench.sv ----
// Self-checking bench for the two-wire slave port
`timescale 1ns/1ps
module clock_gen_i2c_slave_port_bench;
  logic                  clk;
  logic                  rst_n;
  logic                  scl;
  logic                  sda_m;
  logic                  sda_o;
  logic                  sda_oe_n;
  logic                  sda_w;
  sport_pkg::cfg_write_t cfg_wr;
  logic                  ovr;
  logic                  trig;
  logic [7:0]            shadow [0:30];
  logic [12:0]           exp_q [$];
  logic                  a;
  int                    n_fail;
  int                    comparisons;
  int                    n_trig;

  assign sda_w = sda_m & (sda_oe_n | sda_o);

  clock_gen_i2c_slave_port clock_gen_i2c_slave_port_inst (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .cfg_wr(cfg_wr), .register_override_enable(ovr), .acquisition_trigger(trig));
  bus_master bus_master_inst (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  task automatic chk_bit(input string what, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %0b seen %0b", what, e, g);
    end
  endtask : chk_bit

  task automatic chk_val(input string what, input logic [12:0] e, input logic [12:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk_val

  always @(posedge clk) begin
    if (trig === 1'b1) n_trig++;
    if (cfg_wr.valid === 1'b1) chk_val("cfg_wr", exp_q.size() ? exp_q.pop_front() : 13'h1FFF, {cfg_wr.addr, cfg_wr.data});
  end

  task automatic head(input logic [6:0] dev, input logic [7:0] sub, input logic e_ack, input logic e_sub);
    bus_master_inst.start();
    bus_master_inst.wbyte({dev, 1'b0}, a);
    chk_bit("address ack", e_ack, a);
    if (e_ack === 1'b0) bus_master_inst.wbyte(sub, a);
    if (e_ack === 1'b0) chk_bit("subaddress ack", e_sub, a);
  endtask : head

  task automatic wr(input logic [4:0] sub, input logic [7:0] first, input int n);
    logic [4:0] p;
    logic [7:0] d;
    p = sub;
    head(sport_pkg::SLAVE_ADDR, {3'h0, sub}, 1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      d = (i == 0) ? first : 8'($urandom);
      exp_q.push_back({p, d});
      shadow[p] = d;
      bus_master_inst.wbyte(d, a);
      chk_bit("data ack", 1'b0, a);
      if (p < sport_pkg::TOP_SUB) p++;
    end
    bus_master_inst.stop();
  endtask : wr

  task automatic rd(input logic [4:0] sub, input int n);
    logic [4:0] p;
    logic [7:0] d;
    p = sub;
    head(sport_pkg::SLAVE_ADDR, {3'h0, sub}, 1'b0, 1'b0);
    bus_master_inst.start();
    bus_master_inst.wbyte({sport_pkg::SLAVE_ADDR, 1'b1}, a);
    chk_bit("read address ack", 1'b0, a);
    for (int i = 0; i < n; i++) begin
      bus_master_inst.rbyte(i == n - 1, d);
      chk_val("read data", {5'h00, shadow[p]}, {5'h00, d});
      if (p < sport_pkg::TOP_SUB) p++;
    end
    bus_master_inst.stop();
  endtask : rd

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (50000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    n_fail = 0;
    comparisons = 0;
    n_trig = 0;
    foreach (shadow[i]) shadow[i] = sport_pkg::REG_RESET;
    void'($urandom(5636));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(5'h00, 3);
    chk_bit("override", 1'b0, ovr);
    $display("Test reset values done");
    wr(sport_pkg::OVR_CTL_SUB, 8'h02, 1);
    chk_bit("override", 1'b1, ovr);
    $display("Test override done");
    wr(5'h03, 8'($urandom), 4);
    rd(5'h03, 4);
    $display("Test auto increment done");
    wr(5'h1D, 8'($urandom), 2);
    rd(5'h1D, 5);
    $display("Test read past top done");
    for (int i = 0; i < 3; i++) begin
      head(sport_pkg::SLAVE_ADDR, (i == 0) ? 8'h1F : 8'(8'h20 + $urandom % 8'hE0), 1'b0, 1'b1);
      bus_master_inst.wbyte(8'($urandom), a);
      chk_bit("data after bad subaddress", 1'b1, a);
      bus_master_inst.stop();
    end
    $display("Test invalid subaddress done");
    head(7'h41, 8'h00, 1'b1, 1'b1);
    bus_master_inst.stop();
    $display("Test foreign address done");
    bus_master_inst.start();
    for (int i = 0; i < 3; i++) bus_master_inst.bit_io(sport_pkg::SLAVE_ADDR[6 - i], a);
    wr(5'h05, 8'($urandom), 1);
    rd(5'h05, 1);
    $display("Test misplaced start done");
    wr(sport_pkg::ACQ_CTL_SUB, 8'h01, 1);
    wr(sport_pkg::ACQ_CTL_SUB, 8'h00, 1);
    chk_val("trigger count", 13'h0001, 13'(n_trig));
    chk_val("writes outstanding", 13'h0000, 13'(exp_q.size()));
    $display("Test acquisition trigger done");
    print_verdict();
  end
endmodule : clock_gen_i2c_slave_port_bench

// ---- hw/clock_gen_i2c_slave_port.sv ----
// Two-wire slave port with configuration register file
`timescale 1ns/1ps
module clock_gen_i2c_slave_port (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_n,
  output sport_pkg::cfg_write_t      cfg_wr,
  output logic                       register_override_enable,
  output logic                       acquisition_trigger
);
  sport_pkg::line_view_t scl_v;
  sport_pkg::line_view_t sda_v;
  sport_pkg::port_state_t state_ff;
  logic [7:0]  regs_ff [0:sport_pkg::TOP_SUB];
  logic [7:0]  shreg_ff;
  logic [3:0]  cnt_ff;
  logic [4:0]  ptr_ff;
  logic        rw_ff;
  logic        acked_ff;
  logic        sda_oe_n_ff;
  logic        ovr_ff;
  logic        acq_ff;
  logic        acq_start_ff;
  sport_pkg::cfg_write_t cfg_wr_ff;
  logic        start_seen;
  logic        stop_seen;
  logic        byte_done;
  logic [4:0]  nxt_ptr;

  function automatic logic [4:0] advance(input logic [4:0] p);
    advance = (p == sport_pkg::TOP_SUB) ? p : p + 5'h01;
  endfunction : advance

  line_sampler u_scl (.clk(clk), .rst_n(rst_n), .pin(scl_i), .view(scl_v));
  line_sampler u_sda (.clk(clk), .rst_n(rst_n), .pin(sda_i), .view(sda_v));

  assign start_seen = scl_v.level & sda_v.fall;
  assign stop_seen  = scl_v.level & sda_v.rise;
  assign byte_done  = (cnt_ff == sport_pkg::BYTE_BITS);
  assign nxt_ptr    = advance(ptr_ff);

  // Protocol sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= sport_pkg::ST_IDLE;
      shreg_ff    <= sport_pkg::REG_RESET;
      cnt_ff      <= sport_pkg::CNT_ZERO;
      rw_ff       <= 1'b0;
      acked_ff    <= 1'b0;
      sda_oe_n_ff <= 1'b1;
    end else if (start_seen) begin
      state_ff    <= sport_pkg::ST_ADDR;
      cnt_ff      <= sport_pkg::CNT_ZERO;
      sda_oe_n_ff <= 1'b1;
    end else if (stop_seen) begin
      state_ff    <= sport_pkg::ST_IDLE;
      sda_oe_n_ff <= 1'b1;
    end else if (scl_v.rise) begin
      unique case (state_ff)
        sport_pkg::ST_ADDR, sport_pkg::ST_SUB, sport_pkg::ST_WDATA: begin
          if (!byte_done) begin
            shreg_ff <= {shreg_ff[6:0], sda_v.level};
            cnt_ff   <= cnt_ff + sport_pkg::CNT_ONE;
          end
        end
        sport_pkg::ST_RACK: begin
          acked_ff <= ~sda_v.level;
          if (sda_v.level) begin
            state_ff <= sport_pkg::ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_v.fall) begin
      unique case (state_ff)
        sport_pkg::ST_ADDR: begin
          if (byte_done) begin
            cnt_ff <= sport_pkg::CNT_ZERO;
          end
          if (byte_done && shreg_ff[7:1] == sport_pkg::SLAVE_ADDR) begin
            rw_ff       <= shreg_ff[0];
            sda_oe_n_ff <= 1'b0;
            state_ff    <= sport_pkg::ST_ADDR_ACK;
          end else if (byte_done) begin
            state_ff <= sport_pkg::ST_IDLE;
          end
        end
        sport_pkg::ST_ADDR_ACK: begin
          if (rw_ff) begin
            shreg_ff    <= {regs_ff[ptr_ff][6:0], 1'b0};
            sda_oe_n_ff <= regs_ff[ptr_ff][7];
            cnt_ff      <= sport_pkg::CNT_ONE;
            state_ff    <= sport_pkg::ST_RDATA;
          end else begin
            sda_oe_n_ff <= 1'b1;
            state_ff    <= sport_pkg::ST_SUB;
          end
        end
        sport_pkg::ST_SUB: begin
          if (byte_done) begin
            cnt_ff <= sport_pkg::CNT_ZERO;
          end
          if (byte_done && shreg_ff < sport_pkg::NUM_SUB) begin
            sda_oe_n_ff <= 1'b0;
            state_ff    <= sport_pkg::ST_SUB_ACK;
          end else if (byte_done) begin
            state_ff <= sport_pkg::ST_IDLE;
          end
        end
        sport_pkg::ST_SUB_ACK, sport_pkg::ST_WDAT_ACK: begin
          sda_oe_n_ff <= 1'b1;
          state_ff    <= sport_pkg::ST_WDATA;
        end
        sport_pkg::ST_WDATA: begin
          if (byte_done) begin
            cnt_ff      <= sport_pkg::CNT_ZERO;
            sda_oe_n_ff <= 1'b0;
            state_ff    <= sport_pkg::ST_WDAT_ACK;
          end
        end
        sport_pkg::ST_RDATA: begin
          if (byte_done) begin
            sda_oe_n_ff <= 1'b1;
            state_ff    <= sport_pkg::ST_RACK;
          end else begin
            sda_oe_n_ff <= shreg_ff[7];
            shreg_ff    <= {shreg_ff[6:0], 1'b0};
            cnt_ff      <= cnt_ff + sport_pkg::CNT_ONE;
          end
        end
        sport_pkg::ST_RACK: begin
          if (acked_ff) begin
            shreg_ff    <= {regs_ff[ptr_ff][6:0], 1'b0};
            sda_oe_n_ff <= regs_ff[ptr_ff][7];
            cnt_ff      <= sport_pkg::CNT_ONE;
            state_ff    <= sport_pkg::ST_RDATA;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Subaddress pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_ff <= sport_pkg::SUB_RESET;
    end else if (scl_v.fall && !start_seen && !stop_seen) begin
      if (state_ff == sport_pkg::ST_SUB && byte_done && shreg_ff < sport_pkg::NUM_SUB) begin
        ptr_ff <= shreg_ff[4:0];
      end else if (state_ff == sport_pkg::ST_WDATA && byte_done) begin
        ptr_ff <= nxt_ptr;
      end
    end else if (scl_v.rise && !start_seen && !stop_seen && state_ff == sport_pkg::ST_RACK
                 && !sda_v.level) begin
      ptr_ff <= nxt_ptr;
    end
  end

  // Register file write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i <= int'(sport_pkg::TOP_SUB); i++) begin
        regs_ff[i] <= sport_pkg::REG_RESET;
      end
      cfg_wr_ff <= '0;
    end else begin
      cfg_wr_ff.valid <= 1'b0;
      if (scl_v.fall && !start_seen && !stop_seen && state_ff == sport_pkg::ST_WDATA && byte_done) begin
        regs_ff[ptr_ff] <= shreg_ff;
        cfg_wr_ff.valid <= 1'b1;
        cfg_wr_ff.addr  <= ptr_ff;
        cfg_wr_ff.data  <= shreg_ff;
      end
    end
  end

  // Override enable and acquisition toggle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovr_ff       <= 1'b0;
      acq_ff       <= 1'b0;
      acq_start_ff <= 1'b0;
    end else begin
      ovr_ff       <= regs_ff[sport_pkg::OVR_CTL_SUB][sport_pkg::OVR_BIT];
      acq_ff       <= regs_ff[sport_pkg::ACQ_CTL_SUB][sport_pkg::ACQ_BIT];
      acq_start_ff <= acq_ff & ~regs_ff[sport_pkg::ACQ_CTL_SUB][sport_pkg::ACQ_BIT];
    end
  end

  assign sda_o                    = 1'b0;
  assign sda_oe_n                 = sda_oe_n_ff;
  assign cfg_wr                   = cfg_wr_ff;
  assign register_override_enable = ovr_ff;
  assign acquisition_trigger      = acq_start_ff;

  sequence s_addr_end;
    scl_v.fall && !start_seen && !stop_seen && state_ff == sport_pkg::ST_ADDR && byte_done;
  endsequence
  sequence s_sub_end;
    scl_v.fall && !start_seen && !stop_seen && state_ff == sport_pkg::ST_SUB && byte_done;
  endsequence

  AST_START_GOES_ADDR: assert property (@(posedge clk) disable iff (!rst_n) start_seen |=> state_ff == sport_pkg::ST_ADDR && sda_oe_n)
    else $error("start did not restart address phase");
  AST_STOP_GOES_IDLE: assert property (@(posedge clk) disable iff (!rst_n) stop_seen && !start_seen |=> state_ff == sport_pkg::ST_IDLE && sda_oe_n)
    else $error("stop did not return idle");
  AST_OWN_ADDR_ACK: assert property (@(posedge clk) disable iff (!rst_n) s_addr_end ##0 shreg_ff[7:1] == sport_pkg::SLAVE_ADDR |=> !sda_oe_n && state_ff == sport_pkg::ST_ADDR_ACK)
    else $error("own address not acknowledged");
  AST_OTHER_ADDR_IGNORED: assert property (@(posedge clk) disable iff (!rst_n) s_addr_end ##0 shreg_ff[7:1] != sport_pkg::SLAVE_ADDR |=> sda_oe_n && state_ff == sport_pkg::ST_IDLE)
    else $error("foreign address answered");
  AST_BAD_SUB_NACK: assert property (@(posedge clk) disable iff (!rst_n) s_sub_end ##0 shreg_ff >= sport_pkg::NUM_SUB |=> sda_oe_n && state_ff == sport_pkg::ST_IDLE)
    else $error("invalid subaddress acknowledged");
  AST_SUB_LOADS_PTR: assert property (@(posedge clk) disable iff (!rst_n) s_sub_end ##0 shreg_ff < sport_pkg::NUM_SUB |=> ptr_ff == $past(shreg_ff[4:0]))
    else $error("pointer not loaded from subaddress");
  AST_WRITE_ADVANCES: assert property (@(posedge clk) disable iff (!rst_n) cfg_wr_ff.valid |-> ptr_ff == advance(cfg_wr_ff.addr) && !sda_oe_n)
    else $error("pointer not advanced after write");
  AST_PTR_CAPPED: assert property (@(posedge clk) disable iff (!rst_n) ptr_ff <= sport_pkg::TOP_SUB)
    else $error("pointer past top register");
  AST_NACK_ENDS_READ: assert property (@(posedge clk) disable iff (!rst_n) scl_v.rise && !start_seen && !stop_seen && state_ff == sport_pkg::ST_RACK && sda_v.level |=> state_ff == sport_pkg::ST_IDLE ##1 sda_oe_n)
    else $error("read continued after not-acknowledge");
  AST_BYTE_LENGTH: assert property (@(posedge clk) disable iff (!rst_n) cnt_ff <= sport_pkg::BYTE_BITS)
    else $error("bit count beyond one byte");
  AST_OVERRIDE_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n) $rose(register_override_enable) |-> $past(cfg_wr_ff.valid, 1) && $past(cfg_wr_ff.addr, 1) == sport_pkg::OVR_CTL_SUB)
    else $error("override enable changed without a write");
  AST_ACQ_ON_FALL: assert property (@(posedge clk) disable iff (!rst_n) acquisition_trigger |-> $past(acq_ff) && !acq_ff ##1 !acquisition_trigger)
    else $error("acquisition start without one then zero");
endmodule : clock_gen_i2c_slave_port

// ---- hw/line_sampler.sv ----
// Two-flop synchroniser with edge detection for one bus line
`timescale 1ns/1ps
module line_sampler (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                pin,
  output sport_pkg::line_view_t    view
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      last_ff <= 1'b1;
    end else begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign view.level = sync_ff;
  assign view.rise  = sync_ff & ~last_ff;
  assign view.fall  = ~sync_ff & last_ff;
endmodule : line_sampler

// ---- hw/sport_pkg.sv ----
// Constants, types and states of the two-wire slave port
package sport_pkg;
  localparam logic [6:0] SLAVE_ADDR    = 7'h40;
  localparam int         SUB_W         = 5;
  localparam logic [7:0] NUM_SUB       = 8'h1F;
  localparam logic [4:0] TOP_SUB       = 5'h1E;
  localparam logic [4:0] OVR_CTL_SUB   = 5'h00;
  localparam logic [4:0] ACQ_CTL_SUB   = 5'h01;
  localparam int         OVR_BIT       = 1;
  localparam int         ACQ_BIT       = 0;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] CNT_ONE       = 4'h1;
  localparam logic [3:0] CNT_ZERO      = 4'h0;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [4:0] SUB_RESET     = 5'h00;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_ADDR     = 4'b0001,
    ST_ADDR_ACK = 4'b0010,
    ST_SUB      = 4'b0011,
    ST_SUB_ACK  = 4'b0100,
    ST_WDATA    = 4'b0101,
    ST_WDAT_ACK = 4'b0110,
    ST_RDATA    = 4'b0111,
    ST_RACK     = 4'b1000
  } port_state_t;

  typedef struct packed {
    logic             valid;
    logic [SUB_W-1:0] addr;
    logic [7:0]       data;
  } cfg_write_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } line_view_t;
endpackage : sport_pkg
